// ### hw/rsw_pkg.sv
// Package for the reset source and watchdog monitor block.
// Assumes a 50 MHz system clock, a Wishbone slave port and byte-wide registers.
package rsw_pkg;

    // ************************************************************
    // Register map (printed offsets are byte addresses here).
    // ************************************************************
    localparam logic [7:0] RSW_ADDR_CLOCK_SYSTEM_OPTION_2 = 8'h38;
    localparam logic [7:0] RSW_ADDR_OPTIONS = 8'h39;
    localparam logic [7:0] RSW_ADDR_CONFIG = 8'h3F;
    localparam logic [7:0] RSW_ADDR_SERVICE = 8'h3A;
    localparam logic [7:0] RSW_ADDR_TEST = 8'h3E;
    localparam logic [7:0] RSW_ADDR_STATUS = 8'h40;

    localparam logic [7:0] RSW_OPTIONS_RST = 8'h10;
    localparam logic [7:0] RSW_CLOCK_SYSTEM_OPTION_2_RST = 8'h00;
    localparam logic [7:0] RSW_CONFIG_RST = 8'h00;

    // Field positions.
    localparam int RSW_BIT_CME = 3;
    localparam int RSW_BIT_CLOCK_MONITOR_FORCE_ENABLE = 2;
    localparam int RSW_BIT_NOWD = 2;
    localparam int RSW_BIT_DISABLE_RESETS_TEST_BIT = 0;

    localparam logic [7:0] RSW_ARM_CODE = 8'h55;
    localparam logic [7:0] RSW_CLEAR_CODE = 8'hAA;

    // ************************************************************
    // Restart vectors.
    // ************************************************************
    localparam logic [15:0] RSW_VEC_EXT_NORMAL = 16'hFFFE;
    localparam logic [15:0] RSW_VEC_EXT_SPECIAL = 16'hBFFE;
    localparam logic [15:0] RSW_VEC_STEP = 16'h0002;

    // ************************************************************
    // Timing.
    // ************************************************************
    localparam int RSW_CLK_HZ = 50000000;
    localparam int RSW_POR_WAIT_CYC = 4064;
    localparam int RSW_PIN_DRIVE_E = 4;
    localparam int RSW_PIN_SAMPLE_E = 2;
    localparam int RSW_PROTECT_E = 64;
    localparam int RSW_VECTOR_CYC = 3;
    localparam int RSW_WD_BASE_LOG2 = 15;
    localparam int RSW_MON_MIN_HZ = 10000;
    localparam int RSW_MON_TIMEOUT_CYC = RSW_CLK_HZ / RSW_MON_MIN_HZ;
    localparam logic [7:0] RSW_E_DIV_DEFAULT = 8'h04;

    typedef enum logic [2:0] {
        RSW_ST_POR = 3'b000,
        RSW_ST_DRIVE = 3'b001,
        RSW_ST_SETTLE = 3'b010,
        RSW_ST_HOLD = 3'b011,
        RSW_ST_VECTOR = 3'b100,
        RSW_ST_RUN = 3'b101
    } rsw_state_t;

    typedef enum logic [1:0] {
        RSW_CAUSE_EXT = 2'b00,
        RSW_CAUSE_MON = 2'b01,
        RSW_CAUSE_WD = 2'b10
    } rsw_cause_t;

    typedef struct packed {
        logic cyc;
        logic stb;
        logic we;
        logic [7:0] adr;
        logic [7:0] dat;
    } rsw_wb_req_t;

endpackage

// ### hw/rsw_monitor.sv
// Reset source, watchdog and clock monitor for a small microcontroller.
// Assumes one 50 MHz clock, a synchronous reset, and a reset pin split into in/out/oe.
`timescale 1ns/10ps

module rsw_monitor
    import rsw_pkg::*;
#(
    parameter int POR_WAIT_CYC = RSW_POR_WAIT_CYC,
    parameter int MON_TIMEOUT_CYC = RSW_MON_TIMEOUT_CYC
) (
    // Clock and reset.
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave.
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [0:0] wb_sel_i,
    input wire logic [7:0] wb_dat_i,
    output logic [7:0] wb_dat_o,
    output logic wb_ack_o,
    output logic wb_err_o,
    // Mode and clock monitor input.
    input wire logic special_mode_i,
    input wire logic e_clk_tick_i,
    // Reset pin, open drain.
    input wire logic reset_pin_i,
    output logic reset_pin_o,
    output logic reset_pin_oe_o,
    // Core side.
    output logic cpu_reset_o,
    output logic vector_valid_o,
    output logic [15:0] vector_addr_o
);

    // ************************************************************
    // E clock enable divider.
    // ************************************************************
    logic [7:0] ediv_q;
    wire e_en = (ediv_q == 8'h00);
    always_ff @(posedge clk_i) begin
        if (rst_i || e_en) begin
            ediv_q <= RSW_E_DIV_DEFAULT - 8'h01;
        end else begin
            ediv_q <= ediv_q - 8'h01;
        end
    end

    // ************************************************************
    // Bus decode.
    // ************************************************************
    rsw_wb_req_t req;
    assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, dat: wb_dat_i};
    wire bus_go = req.cyc && req.stb && !wb_ack_o && !wb_err_o;
    wire hit_clock_system_option_2 = (req.adr == RSW_ADDR_CLOCK_SYSTEM_OPTION_2);
    wire hit_opt = (req.adr == RSW_ADDR_OPTIONS);
    wire hit_cfg = (req.adr == RSW_ADDR_CONFIG);
    wire hit_svc = (req.adr == RSW_ADDR_SERVICE);
    wire hit_test = (req.adr == RSW_ADDR_TEST);
    wire hit_stat = (req.adr == RSW_ADDR_STATUS);
    wire mapped = hit_clock_system_option_2 || hit_opt || hit_cfg || hit_svc || hit_test || hit_stat;
    wire wr = bus_go && req.we && wb_sel_i[0] && mapped;

    // ************************************************************
    // Registers and state.
    // ************************************************************
    rsw_state_t state_q;
    rsw_cause_t cause_q;
    logic [7:0] opt_q;
    logic [7:0] clock_system_option_2_q;
    logic [7:0] cfg_q;
    logic cfg_written_q;
    logic opt_written_q;
    logic disable_resets_test_bit_q;
    logic [6:0] prot_cnt_q;
    logic [12:0] wait_q;
    logic armed_q;
    logic [21:0] wd_cnt_q;
    logic [15:0] mon_cnt_q;
    logic [1:0] vec_cnt_q;
    logic internal_req;

    wire running = (state_q == RSW_ST_RUN);
    wire prot_open = special_mode_i || (!opt_written_q && prot_cnt_q < 7'(RSW_PROTECT_E));
    wire cfg_open = special_mode_i || !cfg_written_q;
    wire mon_on = opt_q[RSW_BIT_CME] || opt_q[RSW_BIT_CLOCK_MONITOR_FORCE_ENABLE];
    wire wd_on = !cfg_q[RSW_BIT_NOWD] && !disable_resets_test_bit_q;

    function automatic logic [21:0] wd_limit(input logic [1:0] rate);
        wd_limit = 22'(1) << (RSW_WD_BASE_LOG2 + 2 * int'(rate));
    endfunction

    wire wd_expire = running && wd_on && (wd_cnt_q >= wd_limit(opt_q[1:0]) - 22'h1) && e_en;
    wire mon_expire = running && mon_on && (mon_cnt_q >= 16'(MON_TIMEOUT_CYC));
    wire svc_wr = wr && hit_svc && running;
    wire svc_clear = svc_wr && armed_q && (req.dat == RSW_CLEAR_CODE);
    assign internal_req = wd_expire || mon_expire;

    // ************************************************************
    // Register writes.
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || !running) begin
            // Rate resets to 00, monitor enables cleared.
            opt_q <= RSW_OPTIONS_RST;
            clock_system_option_2_q <= RSW_CLOCK_SYSTEM_OPTION_2_RST;
            opt_written_q <= 1'b0;
            disable_resets_test_bit_q <= special_mode_i && !rst_i ? 1'b1 : 1'b0;
            prot_cnt_q <= '0;
        end else begin
            if (e_en && prot_cnt_q < 7'(RSW_PROTECT_E)) begin
                prot_cnt_q <= prot_cnt_q + 7'h01;
            end
            if (wr && hit_opt) begin
                // Enable bit writable at any time; protected bits only in window.
                opt_q[RSW_BIT_CME] <= req.dat[RSW_BIT_CME];
                if (req.dat[RSW_BIT_CLOCK_MONITOR_FORCE_ENABLE]) begin
                    opt_q[RSW_BIT_CLOCK_MONITOR_FORCE_ENABLE] <= 1'b1;
                end
                if (prot_open) begin
                    opt_q[1:0] <= req.dat[1:0];
                    opt_q[7:4] <= req.dat[7:4];
                    opt_written_q <= 1'b1;
                end
            end
            if (wr && hit_clock_system_option_2) begin
                clock_system_option_2_q <= req.dat;
            end
            if (wr && hit_test && !req.dat[RSW_BIT_DISABLE_RESETS_TEST_BIT]) begin
                disable_resets_test_bit_q <= 1'b0;
            end
        end
    end

    // Configuration survives internal resets; only rst_i restores it.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_q <= RSW_CONFIG_RST;
            cfg_written_q <= 1'b0;
        end else if (wr && hit_cfg && cfg_open) begin
            cfg_q <= req.dat;
            cfg_written_q <= 1'b1;
        end
    end

    // ************************************************************
    // Watchdog and service sequence.
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || !running) begin
            wd_cnt_q <= '0;
            armed_q <= 1'b0;
        end else begin
            if (svc_clear) begin
                wd_cnt_q <= '0;
            end else if (e_en && wd_on) begin
                wd_cnt_q <= wd_cnt_q + 22'h1;
            end
            // Arm persists across other accesses until the clear arrives.
            if (svc_wr) begin
                armed_q <= (req.dat == RSW_ARM_CODE) ? 1'b1 : (svc_clear ? 1'b0 : armed_q);
            end
        end
    end

    // The tick stands for an observed E edge; no edge for too long trips the monitor.
    always_ff @(posedge clk_i) begin
        if (rst_i || !running || e_clk_tick_i) begin
            mon_cnt_q <= '0;
        end else if (mon_cnt_q != 16'hFFFF) begin
            mon_cnt_q <= mon_cnt_q + 16'h1;
        end
    end

    // ************************************************************
    // Reset sequencer.
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_q <= RSW_ST_POR;
            cause_q <= RSW_CAUSE_EXT;
            wait_q <= '0;
            vec_cnt_q <= '0;
        end else begin
            case (state_q)
                RSW_ST_POR: begin
                    if (wait_q >= 13'(POR_WAIT_CYC - 1)) begin
                        state_q <= RSW_ST_HOLD;
                        wait_q <= '0;
                    end else begin
                        wait_q <= wait_q + 13'h1;
                    end
                end
                RSW_ST_DRIVE: begin
                    if (e_en) begin
                        if (wait_q >= 13'(RSW_PIN_DRIVE_E - 1)) begin
                            state_q <= RSW_ST_SETTLE;
                            wait_q <= '0;
                        end else begin
                            wait_q <= wait_q + 13'h1;
                        end
                    end
                end
                RSW_ST_SETTLE: begin
                    if (e_en) begin
                        if (wait_q >= 13'(RSW_PIN_SAMPLE_E - 1)) begin
                            // A slow external rise would be read as external.
                            if (!reset_pin_i) begin
                                cause_q <= RSW_CAUSE_EXT;
                            end
                            state_q <= RSW_ST_HOLD;
                            wait_q <= '0;
                        end else begin
                            wait_q <= wait_q + 13'h1;
                        end
                    end
                end
                RSW_ST_HOLD: begin
                    if (reset_pin_i) begin
                        state_q <= RSW_ST_VECTOR;
                        vec_cnt_q <= '0;
                    end
                end
                RSW_ST_VECTOR: begin
                    if (vec_cnt_q >= 2'(RSW_VECTOR_CYC - 1)) begin
                        state_q <= RSW_ST_RUN;
                    end else begin
                        vec_cnt_q <= vec_cnt_q + 2'h1;
                    end
                end
                RSW_ST_RUN: begin
                    if (internal_req || !reset_pin_i) begin
                        state_q <= RSW_ST_DRIVE;
                        wait_q <= '0;
                        cause_q <= mon_expire ? RSW_CAUSE_MON :
                                   (wd_expire ? RSW_CAUSE_WD : RSW_CAUSE_EXT);
                    end
                end
                default: begin
                    state_q <= RSW_ST_POR;
                end
            endcase
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    wire [15:0] vec_base = special_mode_i ? RSW_VEC_EXT_SPECIAL : RSW_VEC_EXT_NORMAL;
    wire [15:0] vec_sel = vec_base - RSW_VEC_STEP * {14'h0, cause_q};

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_err_o <= 1'b0;
            wb_dat_o <= '0;
            vector_addr_o <= RSW_VEC_EXT_NORMAL;
            reset_pin_oe_o <= 1'b0;
            cpu_reset_o <= 1'b1;
            vector_valid_o <= 1'b0;
        end else begin
            wb_ack_o <= bus_go && mapped;
            wb_err_o <= bus_go && !mapped;
            if (bus_go) begin
                wb_dat_o <= hit_opt ? opt_q : hit_clock_system_option_2 ? clock_system_option_2_q : hit_cfg ? cfg_q :
                            hit_test ? {7'h0, disable_resets_test_bit_q} :
                            hit_stat ? {3'h0, cfg_written_q, opt_written_q, armed_q,
                                        cause_q} : 8'h00;
            end
            vector_addr_o <= vec_sel;
            reset_pin_oe_o <= (state_q == RSW_ST_DRIVE) ||
                              (state_q == RSW_ST_RUN && internal_req);
            cpu_reset_o <= !running && !(state_q == RSW_ST_VECTOR);
            vector_valid_o <= (state_q == RSW_ST_VECTOR);
        end
    end

    assign reset_pin_o = 1'b0;

endmodule

// ### dv/rsw_pin_model.sv
// Board model of the open-drain reset pin.
// Assumes a strong pull-up and an external reset switch.
`timescale 1ns/10ps
// ************************************************************
// Pin resolution.
// ************************************************************
module rsw_pin_model (
    // Device side.
    input wire logic oe_i,
    input wire logic drv_i,
    // Board side.
    input wire logic ext_low_i,
    output logic pin_o
);
    // The pull-up restores the pin at once, because a slow rise would be misread as external.
    assign pin_o = (oe_i === 1'b1) ? (drv_i & !ext_low_i) : !ext_low_i;
endmodule

// ### dv/rsw_monitor_checker.sv
// Concurrent checks for the reset source monitor.
// Assumes it is bound to rsw_monitor and sees only its ports.
`timescale 1ns/10ps
// ************************************************************
// Checker.
// ************************************************************
module rsw_monitor_checker
    import rsw_pkg::*;
(
    // Clock, reset and bus.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic wb_ack_o,
    input wire logic wb_err_o,
    // Pin and core.
    input wire logic special_mode_i,
    input wire logic reset_pin_i,
    input wire logic reset_pin_o,
    input wire logic reset_pin_oe_o,
    input wire logic cpu_reset_o,
    input wire logic vector_valid_o,
    input wire logic [15:0] vector_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic req_new;
    logic unmapped;
    assign req_new = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
    assign unmapped = !(wb_adr_i inside {RSW_ADDR_CLOCK_SYSTEM_OPTION_2, RSW_ADDR_OPTIONS, RSW_ADDR_CONFIG,
        RSW_ADDR_SERVICE, RSW_ADDR_TEST, RSW_ADDR_STATUS});
    sequence s_drive;
        reset_pin_oe_o [*8] ##[4:12] !reset_pin_oe_o;
    endsequence
    sequence s_vector;
        vector_valid_o [*3] ##1 !vector_valid_o;
    endsequence
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    a_bus_answer: assert property (req_new |=> (wb_ack_o || wb_err_o))
        else $error("bus access not answered");
    a_err_unmapped: assert property (req_new && unmapped |=> wb_err_o && !wb_ack_o)
        else $error("unmapped access not refused");
    a_vector_three: assert property ($rose(vector_valid_o) |-> s_vector)
        else $error("vector not shown three cycles");
    a_vector_normal: assert property (vector_valid_o && !special_mode_i |->
        vector_addr_o inside {16'hFFFE, 16'hFFFC, 16'hFFFA}) else $error("bad normal vector");
    a_pin_drive: assert property ($rose(reset_pin_oe_o) |-> s_drive)
        else $error("pin drive length wrong");
    a_pin_low: assert property (reset_pin_oe_o |-> !reset_pin_o)
        else $error("pin driven high");
    a_por_hold: assert property ($fell(rst_i) |-> cpu_reset_o [*8])
        else $error("core released during power-on wait");
    a_vector_pin_high: assert property ($rose(vector_valid_o) |-> $past(reset_pin_i))
        else $error("vector while pin low");
endmodule

bind rsw_monitor rsw_monitor_checker u_chk (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_adr_i(wb_adr_i), .wb_ack_o(wb_ack_o),
    .wb_err_o(wb_err_o), .special_mode_i(special_mode_i), .reset_pin_i(reset_pin_i),
    .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o), .cpu_reset_o(cpu_reset_o),
    .vector_valid_o(vector_valid_o), .vector_addr_o(vector_addr_o));

// ### dv/rsw_monitor_tb.sv
// Self-checking bench for the reset source monitor.
// Assumes the package, the design, the pin model and the checker compile first.
`timescale 1ns/10ps
// ************************************************************
// Bench.
// ************************************************************
module rsw_monitor_tb;
    import rsw_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [7:0] wb_adr_i = 8'h00;
    logic [7:0] wb_dat_i = 8'h00;
    logic [0:0] wb_sel_i = 1'b1;
    logic special_mode_i = 1'b0;
    logic e_clk_tick_i = 1'b0;
    logic tick_run = 1'b1;
    logic ext_low = 1'b0;
    logic reset_pin_i, wb_ack_o, wb_err_o, reset_pin_o, reset_pin_oe_o;
    logic cpu_reset_o, vector_valid_o, e_s;
    logic [7:0] wb_dat_o, q_s;
    logic [15:0] vector_addr_o;
    logic [15:0] last_vec = 16'h0000;
    int errors = 0;
    int comparisons = 0;
    int cycles = 0;

    rsw_monitor #(.POR_WAIT_CYC(16), .MON_TIMEOUT_CYC(50)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .wb_err_o(wb_err_o), .special_mode_i(special_mode_i), .e_clk_tick_i(e_clk_tick_i),
        .reset_pin_i(reset_pin_i), .reset_pin_o(reset_pin_o), .reset_pin_oe_o(reset_pin_oe_o),
        .cpu_reset_o(cpu_reset_o), .vector_valid_o(vector_valid_o),
        .vector_addr_o(vector_addr_o));
    rsw_pin_model pin (.oe_i(reset_pin_oe_o), .drv_i(reset_pin_o), .ext_low_i(ext_low),
        .pin_o(reset_pin_i));

    initial begin
        forever #10 clk_i = ~clk_i;
    end

    // Stopping the ticks stands in for a dead oscillator.
    always @(posedge clk_i) begin
        e_clk_tick_i <= tick_run && !e_clk_tick_i;
        cycles <= cycles + 1;
        if (vector_valid_o === 1'b1) begin
            last_vec <= vector_addr_o;
        end
        if (cycles == 6000) begin
            errors++;
            end_of_test();
        end
    end

    task automatic end_of_test();
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
        end
    endtask

    task automatic xfer(input logic we, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= d;
        // Look mid-cycle so the answer launched at an edge is never raced at that edge.
        do begin
            @(negedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && wb_err_o !== 1'b1 && n < 50);
        q_s = wb_dat_o;
        e_s = wb_err_o;
        @(posedge clk_i);
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        chk("bus answer", 16'h0000, {15'h0000, n >= 50});
        chk("bus refusal", {15'h0000, !(a inside {RSW_ADDR_CLOCK_SYSTEM_OPTION_2, RSW_ADDR_OPTIONS,
            RSW_ADDR_CONFIG, RSW_ADDR_SERVICE, RSW_ADDR_TEST, RSW_ADDR_STATUS})},
            {15'h0000, e_s});
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
        xfer(1'b0, a, 8'h00);
        chk($sformatf("register %h", a), {8'h00, x}, {8'h00, q_s & m});
    endtask

    task automatic wait_sig(input int which);
        int n;
        n = 0;
        while ((which ? reset_pin_oe_o !== 1'b1 : cpu_reset_o !== 1'b0) && n < 500) begin
            @(posedge clk_i);
            n++;
        end
        chk("reset progress", 16'h0000, {15'h0000, n >= 500});
        repeat (2) @(posedge clk_i);
    endtask

    task automatic do_reset(input logic mode);
        @(posedge clk_i);
        special_mode_i <= mode;
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        wait_sig(0);
    endtask

    initial begin
        do_reset(1'b0);
        chk("restart vector", 16'hFFFE, last_vec);
        rd(RSW_ADDR_OPTIONS, 8'hFF, RSW_OPTIONS_RST);
        rd(RSW_ADDR_STATUS, 8'h03, 8'h00);
        xfer(1'b0, 8'h00, 8'h00);
        xfer(1'b1, RSW_ADDR_OPTIONS, 8'h1B);
        xfer(1'b1, RSW_ADDR_OPTIONS, 8'h18);
        rd(RSW_ADDR_OPTIONS, 8'hFF, 8'h1B);
        xfer(1'b1, RSW_ADDR_CONFIG, 8'h04);
        xfer(1'b1, RSW_ADDR_CONFIG, 8'h00);
        rd(RSW_ADDR_CONFIG, 8'h04, 8'h04);
        xfer(1'b1, RSW_ADDR_SERVICE, RSW_ARM_CODE);
        rd(RSW_ADDR_OPTIONS, 8'h03, 8'h03);
        rd(RSW_ADDR_STATUS, 8'h04, 8'h04);
        xfer(1'b1, RSW_ADDR_SERVICE, RSW_CLEAR_CODE);
        rd(RSW_ADDR_STATUS, 8'h04, 8'h00);
        xfer(1'b1, RSW_ADDR_SERVICE, RSW_ARM_CODE);
        tick_run <= 1'b0;
        wait_sig(1);
        tick_run <= 1'b1;
        wait_sig(0);
        rd(RSW_ADDR_STATUS, 8'h07, 8'h01);
        chk("restart vector", 16'hFFFC, last_vec);
        rd(RSW_ADDR_OPTIONS, 8'hFF, RSW_OPTIONS_RST);
        ext_low <= 1'b1;
        wait_sig(1);
        repeat (40) @(posedge clk_i);
        ext_low <= 1'b0;
        wait_sig(0);
        rd(RSW_ADDR_STATUS, 8'h03, 8'h00);
        chk("restart vector", 16'hFFFE, last_vec);
        do_reset(1'b1);
        chk("restart vector", 16'hBFFE, last_vec);
        rd(RSW_ADDR_TEST, 8'h01, 8'h01);
        xfer(1'b1, RSW_ADDR_TEST, 8'h00);
        rd(RSW_ADDR_TEST, 8'h01, 8'h00);
        xfer(1'b1, RSW_ADDR_CONFIG, 8'h04);
        xfer(1'b1, RSW_ADDR_CONFIG, 8'h00);
        rd(RSW_ADDR_CONFIG, 8'h04, 8'h00);
        xfer(1'b1, RSW_ADDR_OPTIONS, 8'h14);
        rd(RSW_ADDR_OPTIONS, 8'h0C, 8'h04);
        tick_run <= 1'b0;
        wait_sig(1);
        tick_run <= 1'b1;
        wait_sig(0);
        chk("restart vector", 16'hBFFC, last_vec);
        rd(RSW_ADDR_OPTIONS, 8'h0C, 8'h00);
        end_of_test();
    end
endmodule
